// ---- hdl/scap_cfg.svh ----
`ifndef SCAP_CFG_SVH
`define SCAP_CFG_SVH

// ****************************************************************
// Register bus geometry.
// ****************************************************************
`define SCAP_ADDR_W            8
`define SCAP_DATA_W            32

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define SCAP_OFS_CONTACT_A     8'h98
`define SCAP_OFS_CONTACT_B     8'h9c

// ****************************************************************
// Field positions inside each contact register.
// ****************************************************************
`define SCAP_BIT_INPUT_EN      13
`define SCAP_BIT_OUTPUT_EN     12
`define SCAP_BIT_FAST_OD       11
`define SCAP_BIT_OPEN_DRAIN    10
`define SCAP_BIT_PULL_UP       9
`define SCAP_BIT_WEAK_LOW      8
`define SCAP_BIT_SAMPLED       1
`define SCAP_BIT_DRIVE         0

// ****************************************************************
// Reset values.
// ****************************************************************
`define SCAP_RESET_WORD        32'h0000_0000
`define SCAP_RESET_BIT         1'b0

`endif

// ---- hdl/scap_pkg.sv ----
package scap_pkg;

	// Writable fields of one contact register, in storage form.
	typedef struct packed {
		logic input_en;
		logic output_en;
		logic fast_od;
		logic open_drain;
		logic pull_up;
		logic weak_low_bias;
		logic drive_level;
	} scap_ctrl_s;

	// Everything one pad presents towards its pin.
	typedef struct packed {
		logic pin;
		logic pin_oe;
		logic pull_up;
		logic weak_low_bias;
	} scap_pad_s;

	// Way in which the pad driver treats the written level.
	typedef enum logic [1:0] {
		DRV_OFF   = 2'b00,
		DRV_PUSH  = 2'b01,
		DRV_OPEN  = 2'b10,
		DRV_BOOST = 2'b11
	} scap_drive_e;

endpackage

// ---- hdl/scap_pad.sv ----
`timescale 1ns/1ps

module scap_pad
	import scap_pkg::*;
(
	// Clock and reset.
	input  wire logic       ref_clk_i,
	input  wire logic       rst_b_i,
	// Control from the register file.
	input  wire scap_ctrl_s ctrl_i,
	input  wire logic       mux_sel_i,
	// Pin side.
	input  wire logic       pin_i,
	output scap_pad_s       pad_o,
	output logic            sampled_level_o
);

	// ************************************************************
	// Driver mode decode.
	// ************************************************************

	// Boost takes precedence over plain open drain when both are set.
	function automatic scap_drive_e drive_mode(input scap_ctrl_s c,
	                                           input logic       sel);
		scap_drive_e m;
		m = DRV_PUSH;
		if (!(sel && c.output_en)) begin
			m = DRV_OFF;
		end else if (c.fast_od) begin
			m = DRV_BOOST;
		end else if (c.open_drain) begin
			m = DRV_OPEN;
		end
		return m;
	endfunction

	scap_drive_e mode;
	logic        level_prev_q;
	logic        rise;
	logic        pin_d;
	logic        pin_q;
	logic        oe_d;
	logic        oe_q;
	logic        sampled_q;

	assign mode = drive_mode(ctrl_i, mux_sel_i);
	assign rise = ctrl_i.drive_level & ~level_prev_q;

	// Previous written level, for spotting a rise of the level.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			level_prev_q <= 1'b0;
		end else begin
			level_prev_q <= ctrl_i.drive_level;
		end
	end

	// Next pin level and enable for each driver mode.
	always_comb begin
		pin_d = 1'b0;
		oe_d  = 1'b0;
		unique case (mode)
			DRV_OFF: begin
				pin_d = 1'b0;
				oe_d  = 1'b0;
			end
			DRV_PUSH: begin
				pin_d = ctrl_i.drive_level;
				oe_d  = 1'b1;
			end
			DRV_OPEN: begin
				pin_d = 1'b0;
				oe_d  = ~ctrl_i.drive_level;
			end
			DRV_BOOST: begin
				pin_d = rise;
				oe_d  = ~ctrl_i.drive_level | rise;
			end
		endcase
	end

	// Pin outputs come from flops, so they trail the write by one cycle.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			pin_q <= 1'b0;
			oe_q  <= 1'b0;
		end else begin
			pin_q <= pin_d;
			oe_q  <= oe_d;
		end
	end

	// Input path; a disabled input reads low rather than floating.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			sampled_q <= 1'b0;
		end else begin
			sampled_q <= mux_sel_i & ctrl_i.input_en & pin_i;
		end
	end

	// Pulls follow their control bits directly.
	assign pad_o.pin           = pin_q;
	assign pad_o.pin_oe        = oe_q;
	assign pad_o.pull_up       = ctrl_i.pull_up;
	assign pad_o.weak_low_bias = ctrl_i.weak_low_bias;
	assign sampled_level_o     = sampled_q;

endmodule

// ---- hdl/scap_top.sv ----

`timescale 1ns/1ps
`include "scap_cfg.svh"

module scap_top
	import scap_pkg::*;
(
	// Clock and reset.
	input  wire logic                     ref_clk_i,
	input  wire logic                     rst_b_i,
	// Register port.
	input  wire logic [`SCAP_ADDR_W-1:0]  reg_addr_i,
	input  wire logic [`SCAP_DATA_W-1:0]  reg_wdata_i,
	input  wire logic                     reg_wr_i,
	input  wire logic                     reg_rd_i,
	output logic      [`SCAP_DATA_W-1:0]  reg_rdata_o,
	// Pin multiplexer state.
	input  wire logic                     smart_card_sel_i,
	// Contact A pad.
	input  wire logic                     aux_contact_a_pin_i,
	output logic                          aux_contact_a_pin_o,
	output logic                          aux_contact_a_pin_oe_o,
	output logic                          aux_contact_a_pull_up_o,
	output logic                          aux_contact_a_weak_low_bias_o,
	// Contact B pad.
	input  wire logic                     aux_contact_b_pin_i,
	output logic                          aux_contact_b_pin_o,
	output logic                          aux_contact_b_pin_oe_o,
	output logic                          aux_contact_b_pull_up_o,
	output logic                          aux_contact_b_weak_low_bias_o
);

	// ************************************************************
	// Helper functions.
	// ************************************************************

	// Only the documented fields are kept from a write word.
	function automatic scap_ctrl_s pack_ctrl(
		input logic [`SCAP_DATA_W-1:0] w);
		scap_ctrl_s c;
		c.input_en      = w[`SCAP_BIT_INPUT_EN];
		c.output_en     = w[`SCAP_BIT_OUTPUT_EN];
		c.fast_od       = w[`SCAP_BIT_FAST_OD];
		c.open_drain    = w[`SCAP_BIT_OPEN_DRAIN];
		c.pull_up       = w[`SCAP_BIT_PULL_UP];
		c.weak_low_bias = w[`SCAP_BIT_WEAK_LOW];
		c.drive_level   = w[`SCAP_BIT_DRIVE];
		return c;
	endfunction

	// Builds a read word; every bit not named here reads zero.
	function automatic logic [`SCAP_DATA_W-1:0] read_word(
		input scap_ctrl_s c,
		input logic       sampled);
		logic [`SCAP_DATA_W-1:0] w;
		w = `SCAP_RESET_WORD;
		w[`SCAP_BIT_INPUT_EN]    = c.input_en;
		w[`SCAP_BIT_OUTPUT_EN]   = c.output_en;
		w[`SCAP_BIT_FAST_OD]     = c.fast_od;
		w[`SCAP_BIT_OPEN_DRAIN]  = c.open_drain;
		w[`SCAP_BIT_PULL_UP]     = c.pull_up;
		w[`SCAP_BIT_WEAK_LOW]    = c.weak_low_bias;
		w[`SCAP_BIT_SAMPLED]     = sampled;
		w[`SCAP_BIT_DRIVE]       = c.drive_level;
		return w;
	endfunction

	// Full address compare; partial decode would alias other blocks.
	function automatic logic addr_hit(
		input logic [`SCAP_ADDR_W-1:0] a,
		input logic [`SCAP_ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	// ************************************************************
	// Register storage.
	// ************************************************************

	scap_ctrl_s                contact_a_ctrl_q;
	scap_ctrl_s                contact_b_ctrl_q;
	logic                      wr_a;
	logic                      wr_b;
	logic                      rd_a;
	logic                      rd_b;
	logic [`SCAP_DATA_W-1:0]   rdata_d;
	logic [`SCAP_DATA_W-1:0]   rdata_q;
	logic                      contact_a_sampled_level;
	logic                      contact_b_sampled_level;
	scap_pad_s                 pad_a;
	scap_pad_s                 pad_b;

	// Address decode for the two contact registers.
	assign wr_a = reg_wr_i & addr_hit(reg_addr_i, `SCAP_OFS_CONTACT_A);
	assign wr_b = reg_wr_i & addr_hit(reg_addr_i, `SCAP_OFS_CONTACT_B);
	assign rd_a = reg_rd_i & addr_hit(reg_addr_i, `SCAP_OFS_CONTACT_A);
	assign rd_b = reg_rd_i & addr_hit(reg_addr_i, `SCAP_OFS_CONTACT_B);

	// Contact A control word; reserved and read-only bits are dropped.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			contact_a_ctrl_q <= scap_ctrl_s'(`SCAP_RESET_WORD);
		end else if (wr_a) begin
			contact_a_ctrl_q <= pack_ctrl(reg_wdata_i);
		end
	end

	// Contact B control word, handled the same way as contact A.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			contact_b_ctrl_q <= scap_ctrl_s'(`SCAP_RESET_WORD);
		end else if (wr_b) begin
			contact_b_ctrl_q <= pack_ctrl(reg_wdata_i);
		end
	end

	// ************************************************************
	// Read path.
	// ************************************************************

	// Unmapped addresses read as zero so software sees no stale data.
	always_comb begin
		rdata_d = `SCAP_RESET_WORD;
		if (rd_a) begin
			rdata_d = read_word(contact_a_ctrl_q,
			                    contact_a_sampled_level);
		end else if (rd_b) begin
			rdata_d = read_word(contact_b_ctrl_q,
			                    contact_b_sampled_level);
		end
	end

	// Read data stand only in the cycle after the read strobe.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			rdata_q <= `SCAP_RESET_WORD;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;

	// ************************************************************
	// Pad drivers.
	// ************************************************************

	// Contact A pad; the mux select gates both drive and sampling.
	scap_pad u_pad_a (
		.ref_clk_i       (ref_clk_i),
		.rst_b_i         (rst_b_i),
		.ctrl_i          (contact_a_ctrl_q),
		.mux_sel_i       (smart_card_sel_i),
		.pin_i           (aux_contact_a_pin_i),
		.pad_o           (pad_a),
		.sampled_level_o (contact_a_sampled_level)
	);

	// Contact B pad.
	scap_pad u_pad_b (
		.ref_clk_i       (ref_clk_i),
		.rst_b_i         (rst_b_i),
		.ctrl_i          (contact_b_ctrl_q),
		.mux_sel_i       (smart_card_sel_i),
		.pin_i           (aux_contact_b_pin_i),
		.pad_o           (pad_b),
		.sampled_level_o (contact_b_sampled_level)
	);

	// ************************************************************
	// Pin outputs.
	// ************************************************************

	// Contact A pin signals.
	assign aux_contact_a_pin_o           = pad_a.pin;
	assign aux_contact_a_pin_oe_o        = pad_a.pin_oe;
	assign aux_contact_a_pull_up_o       = pad_a.pull_up;
	assign aux_contact_a_weak_low_bias_o = pad_a.weak_low_bias;

	// Contact B pin signals.
	assign aux_contact_b_pin_o           = pad_b.pin;
	assign aux_contact_b_pin_oe_o        = pad_b.pin_oe;
	assign aux_contact_b_pull_up_o       = pad_b.pull_up;
	assign aux_contact_b_weak_low_bias_o = pad_b.weak_low_bias;

endmodule

// ---- verif/scap_monitor.sv ----
`timescale 1ns/1ps
module scap_monitor
	import scap_pkg::*;
(
	// Clock, reset and register port.
	input wire logic        ref_clk_i,
	input wire logic        rst_b_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic        smart_card_sel_i,
	// Pad outputs.
	input wire logic        aux_contact_a_pin_o,
	input wire logic        aux_contact_a_pin_oe_o,
	input wire logic        aux_contact_a_pull_up_o,
	input wire logic        aux_contact_b_pin_o,
	input wire logic        aux_contact_b_pin_oe_o
);
	// ****************************************************************
	// Shadow of the writable fields.
	// ****************************************************************
	logic [13:0] a_q, b_q, pa_q, pb_q;
	logic        s_q;
	wire         s2 = smart_card_sel_i & s_q;
	wire         ao = aux_contact_a_pin_oe_o;
	wire         ap = aux_contact_a_pin_o;
	wire         bo = aux_contact_b_pin_oe_o;
	wire         bp = aux_contact_b_pin_o;

	// Pads follow the register one cycle late, so keep a delayed copy.
	always_ff @(posedge ref_clk_i) begin
		s_q <= smart_card_sel_i;
		pa_q <= a_q;
		pb_q <= b_q;
		if (!rst_b_i) begin
			a_q <= 14'h0;
			b_q <= 14'h0;
		end else if (reg_wr_i && reg_addr_i == 8'h98) begin
			a_q <= reg_wdata_i[13:0] & 14'h3f01;
		end else if (reg_wr_i && reg_addr_i == 8'h9c) begin
			b_q <= reg_wdata_i[13:0] & 14'h3f01;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	property p_rsv;
		reg_rdata_o[31:14] == 18'h0 && reg_rdata_o[7:2] == 6'h0;
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved read bits set");
	property p_pu;
		aux_contact_a_pull_up_o == a_q[9];
	endproperty
	a_pu: assert property (p_pu)
		else $error("pull-up does not follow register");
	property p_oe;
		!pa_q[12] || !(smart_card_sel_i | s_q) |-> !ao;
	endproperty
	a_oe: assert property (p_oe)
		else $error("pad driven while output disabled");
	property p_od_a;
		s2 && pa_q[12:10] == 3'b101 |-> ao == !pa_q[0] && !(ao && ap);
	endproperty
	a_od_a: assert property (p_od_a)
		else $error("contact A open drain wrong");
	property p_od_b;
		s2 && pb_q[12:10] == 3'b101 |-> bo == !pb_q[0] && !(bo && bp);
	endproperty
	a_od_b: assert property (p_od_b)
		else $error("contact B open drain wrong");
	property p_pp;
		s2 && pa_q[12:10] == 3'b100 |-> ao && ap == pa_q[0];
	endproperty
	a_pp: assert property (p_pp)
		else $error("contact A push-pull level wrong");
	property p_bst_lo;
		s2 && pa_q[12:11] == 2'b11 && !pa_q[0] |-> ao && !ap;
	endproperty
	a_bst_lo: assert property (p_bst_lo)
		else $error("boost mode does not drive low");
	property p_bst;
		s2 && pa_q[12:11] == 2'b11 && ap && ao
			##1 s2 && pa_q[12:11] == 2'b11 && pa_q[0] |-> !ao;
	endproperty
	a_bst: assert property (p_bst)
		else $error("boost high lasts over one cycle");
	c_bst: cover property (s2 && ap && ao ##1 !ao);
	c_od_b: cover property (s2 && pb_q[12:10] == 3'b101 && !bo);
	c_pp: cover property (s2 && pa_q[12:10] == 3'b100 && ap);
endmodule

// ---- verif/scap_card.sv ----
`timescale 1ns/1ps
module scap_card
	import scap_pkg::*;
(
	// Clock and the device's pad controls.
	input  wire logic clk_i,
	input  wire logic pad_i,
	input  wire logic oe_i,
	input  wire logic pu_i,
	input  wire logic pd_i,
	// Card drive, commanded by the bench.
	input  wire logic drv_i,
	input  wire logic lvl_i,
	// Resolved contact level.
	output logic      pin_o
);
	// ****************************************************************
	// Wire resolution.
	// ****************************************************************
	logic t_q;

	// A floating contact wanders, so nothing may lean on its old value.
	always @(posedge clk_i) begin
		t_q <= (t_q !== 1'b1);
	end

	// The card keeps off the wire while the device drives it.
	always_comb begin
		if (oe_i) begin
			pin_o = pad_i;
		end else if (drv_i) begin
			pin_o = lvl_i;
		end else if (pu_i || pd_i) begin
			pin_o = pu_i;
		end else begin
			pin_o = t_q;
		end
	end
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb
	import scap_pkg::*;
;
	// ****************************************************************
	// Stimulus, wires and counters.
	// ****************************************************************
	logic        ref_clk_i;
	logic        rst_b_i = 1'b0;
	logic [7:0]  addr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        sel = 1'b0;
	logic [1:0]  drv = 2'b11;
	logic [1:0]  lvl = 2'b00;
	logic [31:0] w [2];
	logic [31:0] rv;
	wire  [31:0] rdata;
	wire  [1:0]  po, oe, pu, pd, pin;
	int          failures = 0;
	int          n_tests = 0;
	int          cyc = 0;

	scap_top dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .smart_card_sel_i(sel),
		.aux_contact_a_pin_i(pin[0]), .aux_contact_a_pin_o(po[0]),
		.aux_contact_a_pin_oe_o(oe[0]), .aux_contact_a_pull_up_o(pu[0]),
		.aux_contact_a_weak_low_bias_o(pd[0]),
		.aux_contact_b_pin_i(pin[1]), .aux_contact_b_pin_o(po[1]),
		.aux_contact_b_pin_oe_o(oe[1]), .aux_contact_b_pull_up_o(pu[1]),
		.aux_contact_b_weak_low_bias_o(pd[1]));

	for (genvar g = 0; g < 2; g++) begin : g_card
		scap_card u_card (.clk_i(ref_clk_i), .pad_i(po[g]), .oe_i(oe[g]),
			.pu_i(pu[g]), .pd_i(pd[g]), .drv_i(drv[g]), .lvl_i(lvl[g]),
			.pin_o(pin[g]));
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk_i);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_i);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Settled pad state {enable, level}; boost settles like open drain.
	function automatic logic [1:0] pe(input logic [31:0] v, input logic s);
		if (!s || !v[12]) return 2'b00;
		if (v[11] || v[10]) return {!v[0], 1'b0};
		return {1'b1, v[0]};
	endfunction

	// Read value; the bench always drives a contact that has no pull.
	function automatic logic [31:0] er(input logic [31:0] v,
		input logic s, input logic d, input logic l);
		logic [1:0] e;
		logic       x;
		e = pe(v, s);
		x = e[1] ? e[0] : d ? l : v[9];
		return (v & 32'h3f01) | {30'h0, s & v[13] & x, 1'b0};
	endfunction

	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// A hung handshake must not stall the run.
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			test_done();
		end
	end

	initial begin
		void'($urandom(68912));
		repeat (6) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rreg(8'h98 + 8'(i * 4), rv);
			chk(rv, 32'h0);
		end
		$display("test reset done");
		@(posedge ref_clk_i);
		sel <= 1'b1;
		wreg(8'h98, 32'h1800);
		repeat (3) @(posedge ref_clk_i);
		#1 chk({30'h0, oe[0], po[0]}, 32'h2);
		wreg(8'h98, 32'h1801);
		@(posedge ref_clk_i);
		#1 chk({30'h0, oe[0], po[0]}, 32'h3);
		@(posedge ref_clk_i);
		#1 chk({31'h0, oe[0]}, 32'h0);
		$display("test boost done");
		for (int i = 0; i < 60; i++) begin
			@(posedge ref_clk_i);
			sel <= i < 8 ? 1'b1 : 1'($urandom);
			lvl <= 2'($urandom);
			for (int c = 0; c < 2; c++) begin
				w[c] = $urandom;
				if (i < 8) w[c][12:10] = 3'(i);
				drv[c] <= 1'($urandom) | !(w[c][9] | w[c][8]);
				wreg(8'h98 + 8'(c * 4), w[c]);
			end
			wreg(8'ha0 + 8'(i), w[0]);
			repeat (4) @(posedge ref_clk_i);
			#1;
			for (int c = 0; c < 2; c++) begin
				chk({oe[c], po[c]}, pe(w[c], sel));
				chk({pu[c], pd[c]}, w[c][9:8]);
				rreg(8'h98 + 8'(c * 4), rv);
				chk(rv, er(w[c], sel, drv[c], lvl[c]));
			end
			rreg(8'ha0 + 8'(i), rv);
			chk(rv, 32'h0);
		end
		$display("test random done");
		test_done();
	end
endmodule

bind scap_top scap_monitor u_mon (
	.ref_clk_i              (ref_clk_i),
	.rst_b_i                (rst_b_i),
	.reg_addr_i             (reg_addr_i),
	.reg_wdata_i            (reg_wdata_i),
	.reg_wr_i               (reg_wr_i),
	.reg_rdata_o            (reg_rdata_o),
	.smart_card_sel_i       (smart_card_sel_i),
	.aux_contact_a_pin_o    (aux_contact_a_pin_o),
	.aux_contact_a_pin_oe_o (aux_contact_a_pin_oe_o),
	.aux_contact_a_pull_up_o(aux_contact_a_pull_up_o),
	.aux_contact_b_pin_o    (aux_contact_b_pin_o),
	.aux_contact_b_pin_oe_o (aux_contact_b_pin_oe_o)
);
